// File: bench/pdb_dead_band_assertions.sv
// Port checker for the dead-band stage.
`timescale 1ns/1ps
`default_nettype none
module pdb_dead_band_assertions #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Bus
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic              wb_ack_o,
   // PWM path
   input  wire logic              genSignalA,
   input  wire logic              genSignalB,
   input  wire logic              firstOutput,
   input  wire logic              secondOutput
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic        wr;   // Write taken
   logic        tk;   // Request taken
   logic        enQ;  // Enable shadow
   logic [11:0] rQ;   // Rise delay shadow
   logic [11:0] fQ;   // Fall delay shadow
   logic [12:0] hiN;  // Samples A high
   logic [12:0] loN;  // Samples A low
   logic [5:0]  w;    // Word index
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = tk && wb_we_i;
   assign w  = wb_adr_i[7:2];
   // Shadow registers; run counts saturate so they never wrap
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         {enQ, rQ, fQ, hiN, loN} <= '0;
      else
      begin
         if (wr && wb_sel_i[0] && w == 6'h1A) enQ <= wb_dat_i[0];
         if (wr && w == 6'h1B)
            rQ <= {wb_sel_i[1] ? wb_dat_i[11:8] : rQ[11:8], wb_sel_i[0] ? wb_dat_i[7:0] : rQ[7:0]};
         if (wr && w == 6'h1C)
            fQ <= {wb_sel_i[1] ? wb_dat_i[11:8] : fQ[11:8], wb_sel_i[0] ? wb_dat_i[7:0] : fQ[7:0]};
         hiN <= genSignalA ? hiN + {12'h000, ~&hiN} : 13'h0000;
         loN <= genSignalA ? 13'h0000 : loN + {12'h000, ~&loN};
      end
   end
   a_ack_next: assert property (tk |=> wb_ack_o) else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_idle_noack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   a_pass_thru: assert property (!enQ ##1 !enQ |-> firstOutput == $past(genSignalA)
      && secondOutput == $past(genSignalB)) else $error("pass-through wrong");
   a_rise_delay: assert property ($past(enQ) && $stable(rQ) |->
      firstOutput == (hiN > {1'b0, rQ})) else $error("rise delay wrong");
   a_fall_delay: assert property ($past(enQ) && $stable(fQ) |->
      secondOutput == !(loN > {1'b0, fQ})) else $error("fall delay wrong");
   a_first_fall: assert property (enQ && !genSignalA |=> !firstOutput)
      else $error("first output fall late");
   a_second_rise: assert property (enQ && genSignalA |=> secondOutput)
      else $error("second output rise late");
   c_write: cover property (wr);
   c_rise: cover property (enQ && $rose(firstOutput));
   c_swallow: cover property (enQ && hiN == 13'h0002 ##1 !genSignalA);
endmodule // pdb_dead_band_assertions
`default_nettype wire

// File: bench/pdb_power_stage.sv
// Power-stage model counting turn-on edges of leg one and turn-off edges of leg two.
`timescale 1ns/1ps
`default_nettype none
module pdb_power_stage (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  reset,
   // Driven legs
   input  wire logic  firstOutput,
   input  wire logic  secondOutput,
   // Edge counts
   output logic [7:0] riseCnt,
   output logic [7:0] fallCnt
);
   logic firstQ;   // Last first leg level
   logic secondQ;  // Last second leg level
   // Turn-on of leg one, turn-off of leg two
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         {firstQ, secondQ, riseCnt, fallCnt} <= '0;
      else
      begin
         firstQ  <= firstOutput;
         secondQ <= secondOutput;
         if (firstOutput && !firstQ) riseCnt <= riseCnt + 8'h01;
         if (secondQ && !secondOutput) fallCnt <= fallCnt + 8'h01;
      end
   end
endmodule // pdb_power_stage
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the dead-band stage.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk, reset, cyc, stb, we, genA, genB, ack, first, second;
   logic [7:0]  adr, riseCnt, fallCnt, r0, f0;
   logic [3:0]  sel;
   logic [31:0] datW, datR, rd;
   int          errors, nChecks;
   logic [7:0]  offs [4] = '{8'h68, 8'h6C, 8'h70, 8'h74};  // Last one unmapped
   // Alternating A runs; the 6/6 and 4/8 runs keep the software limits
   int          lens [6] = '{6, 6, 2, 2, 4, 8};
   pdb_dead_band dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
      .wb_ack_o(ack), .genSignalA(genA), .genSignalB(genB), .firstOutput(first),
      .secondOutput(second));
   pdb_power_stage stage (.clk(clk), .reset(reset), .firstOutput(first),
      .secondOutput(second), .riseCnt(riseCnt), .fallCnt(fallCnt));
   // One compare for every result
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Classic cycle; request held until ack is sampled
   task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr, datW, sel} <= {2'h3, w, a, d, s};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) errors++;
      rd = datR;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Watchdog, far beyond the sequence length
   initial
   begin
      #20000;
      errors++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      {reset, cyc, stb, we, genA, genB, adr, sel, datW} <= {1'b1, 49'h0};
      errors = 0;
      nChecks = 0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      foreach (offs[i])
      begin
         wbCycle(1'b0, offs[i], 32'h0, 4'hF);
         check(rd, 32'h0);
      end
      wbCycle(1'b1, 8'h6C, 32'hFFFFFFFF, 4'hF);
      wbCycle(1'b1, 8'h6C, 32'h00000003, 4'h1);
      wbCycle(1'b1, 8'h74, 32'hFFFFFFFF, 4'hF);
      wbCycle(1'b0, 8'h6C, 32'h0, 4'hF);
      check(rd, 32'h00000F03);
      wbCycle(1'b1, 8'h6C, 32'h00000003, 4'hF);
      wbCycle(1'b1, 8'h70, 32'h00000002, 4'hF);
      wbCycle(1'b1, 8'h68, 32'hFFFFFFFE, 4'hF);
      wbCycle(1'b0, 8'h68, 32'h0, 4'hF);
      check(rd, 32'h0);
      // Delays set but stage off: straight wires
      for (int v = 0; v < 4; v++)
      begin
         genA <= v[0];
         genB <= v[1];
         repeat (2) @(posedge clk);
         check({30'h0, first, second}, {30'h0, v[0], v[1]});
      end
      wbCycle(1'b1, 8'h68, 32'h00000001, 4'h1);
      genA <= 1'b0;
      repeat (8) @(posedge clk);
      r0 = riseCnt;
      f0 = fallCnt;
      // Short runs break the software limit on purpose to see them swallowed
      foreach (lens[i])
      begin
         genA <= (i % 2 == 0);
         repeat (lens[i]) @(posedge clk);
      end
      check({24'h0, riseCnt - r0}, 32'h2);
      check({24'h0, fallCnt - f0}, 32'h2);
      check({30'h0, first, second}, 32'h0);
      print_verdict();
   end
endmodule // testbench
bind pdb_dead_band pdb_dead_band_assertions #(.ADDR_W(ADDR_W)) chk (.clk(clk), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .genSignalA(genSignalA),
   .genSignalB(genSignalB), .firstOutput(firstOutput), .secondOutput(secondOutput));
`default_nettype wire

// File: logic/pdb_dead_band.sv
// Top of the PWM dead-band stage with its classic Wishbone register slave.
//
// Summary of operation
// R1 - Disabled: A to first, B to second
// R2 - Control bit 0 enables, resets to zero
// R3 - Enabled: signal B ignored completely
// R4 - First output: A with rises delayed
// R5 - Second output: A with falls delayed
// R6 - Rise delay may swallow short high pulse
// R7 - Fall delay may swallow short low gap
// R8 - Delay values ignored while stage disabled
// R9 - Software keeps pulses longer than delays
// R10 - Early return cancels pending edge, restarts
`timescale 1ns/1ps
`default_nettype none
module pdb_dead_band #(
   parameter int ADDR_W = 8,
   parameter int DW     = pdb_pkg::DELAY_W
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [ADDR_W-1:0]         wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [pdb_pkg::DATA_W-1:0] wb_dat_i,
   output logic [pdb_pkg::DATA_W-1:0]      wb_dat_o,
   output logic                           wb_ack_o,
   // Generator signals
   input  wire logic                      genSignalA,
   input  wire logic                      genSignalB,
   // Output pins
   output logic                           firstOutput,
   output logic                           secondOutput
);
   // Refuse widths the decoder or byte lanes cannot serve
   generate
      if (ADDR_W < 8 || DW < 1 || DW > 16)
      begin : gBadParam
         $error("pdb_dead_band: ADDR_W must be >= 8 and DW within 1..16");
      end
   endgenerate

   // Register state
   logic                       enable_q;      // Dead-band enable
   logic                       enable_d;
   logic [DW-1:0]              rising_delay_count_q;   // Rising-edge delay in ticks
   logic [DW-1:0]              rising_delay_count_d;
   logic [DW-1:0]              falling_delay_count_q;   // Falling-edge delay in ticks
   logic [DW-1:0]              falling_delay_count_d;
   // Bus state
   logic                       ack_q;         // Acknowledge, one cycle per access
   logic                       ack_d;
   logic [pdb_pkg::DATA_W-1:0] rdata_q;       // Registered read data
   logic [pdb_pkg::DATA_W-1:0] rdata_d;
   // Output state
   logic                       first_q;       // First output pin level
   logic                       first_d;
   logic                       second_q;      // Second output pin level
   logic                       second_d;
   // Access decode
   logic                       access;        // New access taken this cycle
   logic                       hitCtrl;
   logic                       hitRise;
   logic                       hitFall;

   // Links to the two delay units
   pdb_delay_if #(.DW(DW)) riseLink ();
   pdb_delay_if #(.DW(DW)) fallLink ();

   // Compare the word index of an address against a register offset
   function automatic logic addrHit(input logic [ADDR_W-1:0] adr,
                                    input logic [7:0] off);
      addrHit = (adr[pdb_pkg::IDX_HI:pdb_pkg::IDX_LO]
                 == off[pdb_pkg::IDX_HI:pdb_pkg::IDX_LO]);
   endfunction

   // Merge write data into a delay field under the byte enables
   function automatic logic [DW-1:0] mergeDelay(input logic [DW-1:0] old,
                                                input logic [31:0] wdat,
                                                input logic [3:0]  sel);
      logic [15:0] tmp;
      tmp = 16'h0000;
      tmp[DW-1:0] = old;
      if (sel[0])
      begin
         tmp[7:0] = wdat[7:0];
      end
      if (sel[1])
      begin
         tmp[15:8] = wdat[15:8];
      end
      mergeDelay = tmp[DW-1:0];
   endfunction

   // Widen a delay field to a bus word, upper bits read as zero
   function automatic logic [31:0] widenDelay(input logic [DW-1:0] val);
      logic [31:0] tmp;
      tmp = 32'h0000_0000;
      tmp[DW-1:0] = val;
      widenDelay = tmp;
   endfunction

   // A request is taken only once; ack falls the cycle after it rose
   assign access  = wb_cyc_i && wb_stb_i && !ack_q;
   assign hitCtrl = addrHit(wb_adr_i, pdb_pkg::OFF_CONTROL);
   assign hitRise = addrHit(wb_adr_i, pdb_pkg::OFF_RISE);
   assign hitFall = addrHit(wb_adr_i, pdb_pkg::OFF_FALL);

   // Register file next state: writes land on the edge that raises ack
   always_comb
   begin
      enable_d    = enable_q;
      rising_delay_count_d = rising_delay_count_q;
      falling_delay_count_d = falling_delay_count_q;
      ack_d       = access;
      rdata_d     = rdata_q;
      if (access && wb_we_i)
      begin
         // Unmapped writes are acknowledged and dropped
         if (hitCtrl && wb_sel_i[0])
         begin
            enable_d = wb_dat_i[pdb_pkg::CTRL_EN_BIT];   // R2
         end
         if (hitRise)
         begin
            rising_delay_count_d = mergeDelay(rising_delay_count_q, wb_dat_i, wb_sel_i);
         end
         if (hitFall)
         begin
            falling_delay_count_d = mergeDelay(falling_delay_count_q, wb_dat_i, wb_sel_i);
         end
      end
      if (access && !wb_we_i)
      begin
         // Reserved bits and unmapped words read as zero
         rdata_d = 32'h0000_0000;
         if (hitCtrl)
         begin
            rdata_d[pdb_pkg::CTRL_EN_BIT] = enable_q;
         end
         else if (hitRise)
         begin
            rdata_d = widenDelay(rising_delay_count_q);
         end
         else if (hitFall)
         begin
            rdata_d = widenDelay(falling_delay_count_q);
         end
      end
   end

   // Register file and bus flops
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         enable_q    <= pdb_pkg::CTRL_EN_RST;    // R2
         rising_delay_count_q <= DW'(pdb_pkg::RISE_RST);
         falling_delay_count_q <= DW'(pdb_pkg::FALL_RST);
         ack_q       <= 1'b0;
         rdata_q     <= 32'h0000_0000;
      end
      else
      begin
         enable_q    <= enable_d;
         rising_delay_count_q <= rising_delay_count_d;
         falling_delay_count_q <= falling_delay_count_d;
         ack_q       <= ack_d;
         rdata_q     <= rdata_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   // Both units watch signal A only; B never reaches them
   assign riseLink.srcLevel   = genSignalA;      // R3
   assign riseLink.delayCount = rising_delay_count_q;
   assign fallLink.srcLevel   = genSignalA;      // R3
   assign fallLink.delayCount = falling_delay_count_q;

   // Rising edges of A postponed for the first output
   pdb_edge_delay #(
      .DW      (DW),
      .DELAY_HI(1'b1)
   ) uRise (
      .clk  (clk),
      .reset(reset),
      .port (riseLink.unit)
   );

   // Falling edges of A postponed for the second output
   pdb_edge_delay #(
      .DW      (DW),
      .DELAY_HI(1'b0)
   ) uFall (
      .clk  (clk),
      .reset(reset),
      .port (fallLink.unit)
   );

   // Output selection. Units run even when disabled so that turning the
   // stage on mid-pulse shows an already settled delay state; their result
   // is simply not selected, which keeps the delays out of pass-through.
   always_comb
   begin
      if (enable_q)
      begin
         first_d  = riseLink.nextLevel;          // R4 R6
         second_d = fallLink.nextLevel;          // R5 R7
      end
      else
      begin
         first_d  = genSignalA;                  // R1 R8
         second_d = genSignalB;                  // R1 R8
      end
   end

   // Output pin flops, one cycle behind the selected level in both modes
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         first_q  <= 1'b0;
         second_q <= 1'b0;
      end
      else
      begin
         first_q  <= first_d;
         second_q <= second_d;
      end
   end

   assign firstOutput  = first_q;
   assign secondOutput = second_q;
endmodule // pdb_dead_band
`default_nettype wire

// File: logic/pdb_delay_if.sv
// Interface between the dead-band top and one edge-delay unit.
`timescale 1ns/1ps
`default_nettype none
interface pdb_delay_if #(
   parameter int DW = 12
);
   logic          srcLevel;    // Generator signal as seen by the unit
   logic [DW-1:0] delayCount;  // Ticks to postpone the qualifying edge
   logic          nextLevel;   // Next output level computed by the unit

   // Unit side
   modport unit (
      input  srcLevel,
      input  delayCount,
      output nextLevel
   );
   // Top side
   modport top (
      output srcLevel,
      output delayCount,
      input  nextLevel
   );
endinterface : pdb_delay_if
`default_nettype wire

// File: logic/pdb_edge_delay.sv
// Edge-delay unit: postpones one kind of edge of a level by a tick count.
`timescale 1ns/1ps
`default_nettype none
module pdb_edge_delay #(
   parameter int DW       = 12,
   parameter bit DELAY_HI = 1'b1  // 1: delay rising edges, 0: delay falling edges
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Link to the top
   pdb_delay_if.unit port
);
   logic          act;        // Source normalised so the delayed edge is a rise
   logic          actOut_q;   // Normalised output level
   logic          actOut_d;
   logic [DW-1:0] cnt_q;      // Ticks elapsed since the qualifying edge
   logic [DW-1:0] cnt_d;

   assign act = port.srcLevel ^ ~DELAY_HI;

   // Next state: undelayed edge follows at once, delayed edge waits for the count
   always_comb
   begin
      actOut_d = actOut_q;
      cnt_d    = cnt_q;
      if (!act)
      begin
         // Source back at rest: cancel any pending edge, restart next time
         actOut_d = 1'b0;                 // R10
         cnt_d    = '0;                   // R10
      end
      else if (!actOut_q)
      begin
         // Waiting; a pulse no longer than the delay is swallowed whole
         if (cnt_q >= port.delayCount)    // R4 R5 R6 R7
         begin
            actOut_d = 1'b1;
         end
         else
         begin
            cnt_d = DW'(cnt_q + 1'b1);
         end
      end
   end

   // Register the unit state
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         actOut_q <= 1'b0;
         cnt_q    <= '0;
      end
      else
      begin
         actOut_q <= actOut_d;
         cnt_q    <= cnt_d;
      end
   end

   // Undo the normalisation for the top
   assign port.nextLevel = actOut_d ^ ~DELAY_HI;
endmodule // pdb_edge_delay
`default_nettype wire

// File: logic/pdb_pkg.sv
// Shared constants for the PWM dead-band stage: register map, fields and resets.
package pdb_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0]  OFF_CONTROL   = 8'h68;
   localparam logic [7:0]  OFF_RISE      = 8'h6C;
   localparam logic [7:0]  OFF_FALL      = 8'h70;
   // Word-index part of the address that is decoded
   localparam int          IDX_HI        = 7;
   localparam int          IDX_LO        = 2;
   // Control field positions
   localparam int          CTRL_EN_BIT   = 0;
   // Delay fields occupy bits DELAY_W-1:0
   localparam int          DELAY_W       = 12;
   // Reset values
   localparam logic        CTRL_EN_RST   = 1'h0;
   localparam logic [11:0] RISE_RST      = 12'h000;
   localparam logic [11:0] FALL_RST      = 12'h000;
   // Bus data width
   localparam int          DATA_W        = 32;
endpackage : pdb_pkg
